// ==== hw/modbus_cmd_db_regs.svh ====
// Purpose: offsets, field positions and codes of the command and database map
// Assumes: register locations are Modbus register numbers as seen by the host
// Notes: definitions only
`ifndef MODBUS_CMD_DB_REGS_SVH
`define MODBUS_CMD_DB_REGS_SVH
// write-only command locations
`define LOC_LOOP_RECONFIGURE 16'h0003
`define LOC_ROLE_SWAP 16'h0004
`define LOC_ALARM_ACCEPT 16'h0005
`define LOC_SHUTDOWN_BROADCAST 16'h0006
`define LOC_UPLOAD_START 16'h00FF
// station read-only area and database base
`define STATION_TOP 16'h00FF
`define DB_BASE 16'h0100
// discrete view of the digital input parameter
`define DI_DISC_BASE 16'h0780
// database blocks with special handling
`define BLK_DIGITAL 5'h02
`define BLK_ALARM 5'h03
`define BLK_RELAY 5'h04
`define BLK_ANALOG_OUT 5'h05
// flag positions merged into the digital input parameter
`define DI_NEW_ALARM_BIT 11
`define DI_ANY_ALARM_BIT 12
// function codes
`define FC_READ_DISCRETE 8'h02
`define FC_READ_HOLDING 8'h03
`define FC_READ_INPUT 8'h04
`define FC_WRITE_COIL 8'h05
`define FC_WRITE_REG 8'h06
`define FC_WRITE_COILS 8'h0F
`define FC_WRITE_REGS 8'h10
// exception codes
`define EXC_ILLEGAL_FUNCTION 8'h01
`define EXC_ILLEGAL_ADDRESS 8'h02
`endif

// ==== hw/modbus_cmd_db_pkg.sv ====
// Purpose: shared types of the command and database block
// Assumes: nothing beyond the register header
// Notes: types only
package modbus_cmd_db_pkg;
  // answer serialiser states
  typedef enum logic [1:0] {SendIdle, SendHigh, SendLow} send_state_t;
  // decoded database location
  typedef struct packed {
    logic hit;
    logic [4:0] blk;
    logic [2:0] prm;
    logic [5:0] unit;
  } db_loc_t;
endpackage : modbus_cmd_db_pkg

// ==== hw/modbus_cmd_db.sv ====
// Purpose: command decode and field unit database behind the Modbus host
// Assumes: the framing layer hands over one item per request, already
//   split from multi-item transfers; field_control_unit data comes in on
//   the field port; all inputs are on clk
// Notes: one answer per accepted request, bytes sent high byte first
// Notes on behaviour
// - writes outside command set and output items get an error
// - non-zero data fires command, zero does nothing
// - coil and register writes both accepted
// - location 3 starts loop reconfiguration
// - location 4 swaps main and standby role
// - swap only when part of standby pair
// - location 5 accepts current alarms
// - location 6 broadcasts emergency shutdown on loop
// - location 255 starts unit data upload
// - command locations read back read-only data
// - per unit 32 blocks of eight words
// - items readable as discrete or register
// - sixteen bits read as one register
// - database write address is register location
// - relay off only for zero value
// - register sent high byte first
// - digital parameter carries alarm presence flags
// - alarm bit clears after gone, read, accepted
// - last reported analogue value is served
// - outputs forwarded, never stored locally
// - unsupported item reads as zero, except alarm flags of digital parameter
`timescale 1ns/1ns
`include "modbus_cmd_db_regs.svh"
module modbus_cmd_db
  import modbus_cmd_db_pkg::*;
#(
  parameter int UNITS = 60 // field units on the loop
)(
  input wire logic clk, // 250 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic reqValid, // host request present
  output logic reqReady, // request can be taken this cycle
  input wire logic [7:0] reqFunc, // Modbus function code
  input wire logic [15:0] reqAddr, // register or discrete location
  input wire logic [15:0] reqData, // write data
  output logic rspValid, // answer pulse
  output logic rspExc, // answer is an exception
  output logic [7:0] rspExcCode, // exception code
  output logic [15:0] rspData, // read value
  output logic byteValid, // answer byte pulse
  output logic [7:0] byteData, // answer byte
  input wire logic hotStandbyPair, // unit is in a redundant pair
  output logic loopReconfigure, // command pulse
  output logic roleSwap, // command pulse
  output logic alarmAccept, // command pulse
  output logic emergencyShutdown, // emergency_shutdown_command pulse
  output logic uploadStart, // command pulse
  input wire logic stWrValid, // station info update
  input wire logic [7:0] stWrAddr, // station info location
  input wire logic [15:0] stWrData, // station info value
  input wire logic fldWrValid, // field unit report
  input wire logic [5:0] fldUnit, // reporting unit, zero based
  input wire logic [4:0] fldBlock, // reported block
  input wire logic [2:0] fldParam, // reported parameter
  input wire logic [15:0] fldData, // reported value
  input wire logic fldTypeValid, // unit type learnt
  input wire logic [5:0] fldTypeUnit, // unit whose type is learnt
  input wire logic [31:0] fldTypeMask, // blocks supported by that type
  output logic fwdValid, // output write to a unit
  output logic [5:0] fwdUnit, // target unit, zero based
  output logic [4:0] fwdBlock, // target block
  output logic [2:0] fwdParam, // target parameter
  output logic [15:0] fwdData // value sent to the unit
);

  localparam int STRIDE = UNITS * 8; // locations per block
  localparam int DB_WORDS = UNITS * 256; // words in the database

  // storage
  logic [15:0] db [DB_WORDS]; // last reported values, no reset
  logic [15:0] stInfo [256]; // station read-only data
  logic [31:0] supMask_q [UNITS]; // supported blocks per unit
  logic [15:0] almSrc_q [UNITS]; // live alarm condition
  logic [15:0] almLatch_q [UNITS]; // latched alarm bits
  logic [15:0] almRead_q [UNITS]; // bits seen by a host read
  logic [15:0] almAcc_q [UNITS]; // bits read and accepted
  send_state_t sendSt_q; // serialiser state
  logic [15:0] sendWord_q; // word being sent

  // decode a register location into the database
  function automatic db_loc_t dbDecode(input logic [15:0] a);
    db_loc_t r;
    int off;
    int rem;
    off = int'(a) - int'(`DB_BASE);
    rem = (off < 0) ? 0 : off % STRIDE;
    r.hit = (off >= 0) && (off < 32 * STRIDE);
    r.blk = 5'((off < 0) ? 0 : off / STRIDE);
    r.prm = 3'(rem / UNITS);
    r.unit = 6'(rem % UNITS);
    return r;
  endfunction : dbDecode

  // flat index of a unit, block and parameter
  function automatic int dbIndex(input logic [5:0] u, input logic [4:0] b,
                                 input logic [2:0] p);
    return int'(u) * 256 + int'(b) * 8 + int'(p);
  endfunction : dbIndex

  // request decode, combinational
  db_loc_t loc; // register view of the location
  db_loc_t dloc; // database location behind a discrete read
  logic [3:0] dbit; // bit picked by a discrete read
  logic isWrite; // any of the four write codes
  logic isCmd; // location is a command register
  logic isOut; // location is a writable output item
  logic take; // request taken this cycle
  logic [15:0] rdWord; // word a read returns
  logic rdOk; // read location exists
  logic [15:0] dAddr; // register location behind a discrete

  assign reqReady = (sendSt_q == SendIdle);
  assign take = reqValid && reqReady;
  assign isWrite = (reqFunc == `FC_WRITE_COIL) ||
                   (reqFunc == `FC_WRITE_REG) ||
                   (reqFunc == `FC_WRITE_COILS) ||
                   (reqFunc == `FC_WRITE_REGS);
  assign isCmd = (reqAddr == `LOC_LOOP_RECONFIGURE) ||
                 (reqAddr == `LOC_ROLE_SWAP) ||
                 (reqAddr == `LOC_ALARM_ACCEPT) ||
                 (reqAddr == `LOC_SHUTDOWN_BROADCAST) ||
                 (reqAddr == `LOC_UPLOAD_START);
  // writes address registers whatever the code used
  assign loc = dbDecode(reqAddr);
  assign isOut = loc.hit && (int'(loc.unit) < UNITS) &&
                 ((loc.blk == `BLK_RELAY) || (loc.blk == `BLK_ANALOG_OUT));

  // discrete view: digital input window, else sixteen bits per register
  always_comb
  begin
    if (reqAddr >= `DI_DISC_BASE &&
        int'(reqAddr) < int'(`DI_DISC_BASE) + UNITS * 16)
    begin
      dAddr = 16'(int'(`DB_BASE) + 2 * STRIDE +
                  (int'(reqAddr) - int'(`DI_DISC_BASE)) / 16);
    end
    else
    begin
      dAddr = {4'h0, reqAddr[15:4]};
    end
    dbit = reqAddr[3:0];
  end
  assign dloc = dbDecode(dAddr);

  // word lookup for register and discrete reads
  always_comb
  begin
    db_loc_t l;
    logic [15:0] a;
    a = (reqFunc == `FC_READ_DISCRETE) ? dAddr : reqAddr;
    l = (reqFunc == `FC_READ_DISCRETE) ? dloc : loc;
    rdWord = 16'h0000;
    rdOk = 1'b0;
    if (a <= `STATION_TOP)
    begin
      // command locations give station data, never the write
      rdWord = stInfo[a[7:0]];
      rdOk = 1'b1;
    end
    else if (l.hit && int'(l.unit) < UNITS)
    begin
      rdOk = 1'b1;
      if (!supMask_q[l.unit][l.blk])
        rdWord = 16'h0000;
      else if (l.blk == `BLK_ALARM && l.prm == 3'h0)
        rdWord = almLatch_q[l.unit];
      else
        rdWord = db[dbIndex(l.unit, l.blk, l.prm)];
      if (l.blk == `BLK_DIGITAL && l.prm == 3'h0)
      begin
        // presence of latched and of unread alarms
        rdWord[`DI_ANY_ALARM_BIT] = |almLatch_q[l.unit];
        rdWord[`DI_NEW_ALARM_BIT] =
          |(almLatch_q[l.unit] & ~almRead_q[l.unit]);
      end
    end
  end

  // answer and command pulses
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rspValid <= 1'b0;
      rspExc <= 1'b0;
      rspExcCode <= 8'h00;
      rspData <= 16'h0000;
      loopReconfigure <= 1'b0;
      roleSwap <= 1'b0;
      alarmAccept <= 1'b0;
      emergencyShutdown <= 1'b0;
      uploadStart <= 1'b0;
    end
    else
    begin
      rspValid <= take;
      loopReconfigure <= 1'b0;
      roleSwap <= 1'b0;
      alarmAccept <= 1'b0;
      emergencyShutdown <= 1'b0;
      uploadStart <= 1'b0;
      if (take)
      begin
        rspExc <= 1'b0;
        rspExcCode <= 8'h00;
        rspData <= 16'h0000;
        if (isWrite)
        begin
          if (!isCmd && !isOut)
          begin
            rspExc <= 1'b1;
            rspExcCode <= `EXC_ILLEGAL_ADDRESS;
          end
          else if (reqData != 16'h0000)
          begin
            loopReconfigure <= (reqAddr == `LOC_LOOP_RECONFIGURE);
            roleSwap <= (reqAddr == `LOC_ROLE_SWAP) &&
                        hotStandbyPair;
            alarmAccept <= (reqAddr == `LOC_ALARM_ACCEPT);
            emergencyShutdown <=
              (reqAddr == `LOC_SHUTDOWN_BROADCAST);
            uploadStart <= (reqAddr == `LOC_UPLOAD_START);
          end
          rspData <= reqData;
        end
        else if (reqFunc == `FC_READ_DISCRETE ||
                 reqFunc == `FC_READ_INPUT ||
                 reqFunc == `FC_READ_HOLDING)
        begin
          if (!rdOk)
          begin
            rspExc <= 1'b1;
            rspExcCode <= `EXC_ILLEGAL_ADDRESS;
          end
          else if (reqFunc == `FC_READ_DISCRETE)
            rspData <= {15'h0000, rdWord[dbit]};
          else
            rspData <= rdWord;
        end
        else
        begin
          // unknown code
          rspExc <= 1'b1;
          rspExcCode <= `EXC_ILLEGAL_FUNCTION;
        end
      end
    end
  end

  // output items go straight to the unit; relays become on or off
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fwdValid <= 1'b0;
      fwdUnit <= 6'h00;
      fwdBlock <= 5'h00;
      fwdParam <= 3'h0;
      fwdData <= 16'h0000;
    end
    else
    begin
      fwdValid <= take && isWrite && isOut;
      if (take && isWrite && isOut)
      begin
        fwdUnit <= loc.unit;
        fwdBlock <= loc.blk;
        fwdParam <= loc.prm;
        if (loc.blk == `BLK_RELAY)
          fwdData <= {15'h0000, reqData != 16'h0000};
        else
          fwdData <= reqData;
      end
    end
  end

  // serialiser, high byte leaves first
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sendSt_q <= SendIdle;
      sendWord_q <= 16'h0000;
      byteValid <= 1'b0;
      byteData <= 8'h00;
    end
    else
    begin
      byteValid <= 1'b0;
      case (sendSt_q)
        SendIdle:
          if (take && !isWrite && rdOk &&
              (reqFunc == `FC_READ_INPUT || reqFunc == `FC_READ_HOLDING ||
               reqFunc == `FC_READ_DISCRETE))
          begin
            sendSt_q <= SendHigh;
            sendWord_q <= (reqFunc == `FC_READ_DISCRETE) ?
                          {15'h0000, rdWord[dbit]} : rdWord;
          end
        SendHigh:
        begin
          byteValid <= 1'b1;
          byteData <= sendWord_q[15:8];
          sendSt_q <= SendLow;
        end
        SendLow:
        begin
          byteValid <= 1'b1;
          byteData <= sendWord_q[7:0];
          sendSt_q <= SendIdle;
        end
        default:
          sendSt_q <= SendIdle;
      endcase
    end
  end

  // database and station data stores, updated without the host
  always_ff @(posedge clk)
  begin
    if (fldWrValid && int'(fldUnit) < UNITS)
      db[dbIndex(fldUnit, fldBlock, fldParam)] <= fldData;
    if (stWrValid)
      stInfo[stWrAddr] <= stWrData;
  end

  // supported blocks per unit type
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int u = 0; u < UNITS; u++)
        supMask_q[u] <= 32'h0000_0000;
    end
    else if (fldTypeValid && int'(fldTypeUnit) < UNITS)
      supMask_q[fldTypeUnit] <= fldTypeMask;
  end

  // alarm latching; a live condition wins over any clear
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int u = 0; u < UNITS; u++)
      begin
        almSrc_q[u] <= 16'h0000;
        almLatch_q[u] <= 16'h0000;
        almRead_q[u] <= 16'h0000;
        almAcc_q[u] <= 16'h0000;
      end
    end
    else
    begin
      for (int u = 0; u < UNITS; u++)
      begin
        logic [15:0] src;
        logic [15:0] clr;
        logic [15:0] rd;
        src = almSrc_q[u];
        rd = almRead_q[u];
        if (fldWrValid && int'(fldUnit) == u && fldBlock == `BLK_ALARM &&
            fldParam == 3'h0)
          src = fldData;
        // a host read of the alarm word marks its bits as seen
        if (take && (reqFunc == `FC_READ_INPUT ||
                     reqFunc == `FC_READ_HOLDING) &&
            loc.hit && int'(loc.unit) == u && loc.blk == `BLK_ALARM &&
            loc.prm == 3'h0)
          rd = rd | almLatch_q[u];
        clr = almAcc_q[u] & ~src;
        almSrc_q[u] <= src;
        almLatch_q[u] <= src | (almLatch_q[u] & ~clr);
        almRead_q[u] <= rd & ~clr & (src | almLatch_q[u]);
        almAcc_q[u] <= (alarmAccept ? (almAcc_q[u] | rd) : almAcc_q[u]) &
                       ~clr;
      end
    end
  end

  // checks
  sequence cmdWrite(logic [15:0] a);
    take && isWrite && reqAddr == a && reqData != 16'h0000;
  endsequence

  a_reconf_pulse: assert property (@(posedge clk) disable iff (srst)
    cmdWrite(`LOC_LOOP_RECONFIGURE) ##1
    !(take && reqAddr == `LOC_LOOP_RECONFIGURE) |->
      loopReconfigure ##1 !loopReconfigure)
    else $error("reconfigure pulse missing");
  a_zero_quiet: assert property (@(posedge clk) disable iff (srst)
    take && isWrite && reqData == 16'h0000 |=> !(loopReconfigure ||
      roleSwap || alarmAccept || emergencyShutdown || uploadStart))
    else $error("zero write fired a command");
  a_swap_gated: assert property (@(posedge clk) disable iff (srst)
    roleSwap |-> $past(hotStandbyPair) && $past(reqAddr) == `LOC_ROLE_SWAP)
    else $error("swap without standby pair");
  a_bad_write: assert property (@(posedge clk) disable iff (srst)
    take && isWrite && !isCmd && !isOut |=> rspValid && rspExc &&
      rspExcCode == `EXC_ILLEGAL_ADDRESS && !fwdValid)
    else $error("bad write not refused");
  a_shutdown_cmd: assert property (@(posedge clk) disable iff (srst)
    cmdWrite(`LOC_SHUTDOWN_BROADCAST) |=> emergencyShutdown && !uploadStart)
    else $error("shutdown not broadcast");
  a_upload_cmd: assert property (@(posedge clk) disable iff (srst)
    uploadStart |-> $past(reqAddr) == `LOC_UPLOAD_START && $past(take))
    else $error("upload from wrong location");
  a_byte_order: assert property (@(posedge clk) disable iff (srst)
    rspValid && !rspExc && sendSt_q == SendHigh |=>
      byteValid && byteData == $past(rspData[15:8]) ##1
      byteValid && byteData == $past(rspData[7:0], 2))
    else $error("bytes out of order");
  a_relay_level: assert property (@(posedge clk) disable iff (srst)
    take && isWrite && isOut && loc.blk == `BLK_RELAY |=>
      fwdValid && fwdData == {15'h0000, $past(reqData) != 16'h0000})
    else $error("relay value wrong");
  a_alarm_hold: assert property (@(posedge clk) disable iff (srst)
    fldWrValid && fldBlock == `BLK_ALARM && fldParam == 3'h0 &&
    int'(fldUnit) < UNITS |=> (almLatch_q[$past(fldUnit)] & $past(fldData))
      == $past(fldData))
    else $error("alarm not latched");

endmodule : modbus_cmd_db

// ==== sim/field_unit_model.sv ====
// Purpose: field side stand-in, feeds station data, types and reports
// Assumes: driven from the bench, one update per call, on falling edges
// Notes: released data lines show inverted values, never the old ones
`timescale 1ns/1ns
module field_unit_model (
  input wire logic clk, // system clock
  output logic stWrValid, // station info update
  output logic [7:0] stWrAddr, // station info location
  output logic [15:0] stWrData, // station info value
  output logic fldWrValid, // unit report strobe
  output logic [5:0] fldUnit, // reporting unit
  output logic [4:0] fldBlock, // reported block
  output logic [2:0] fldParam, // reported parameter
  output logic [15:0] fldData, // reported value
  output logic fldTypeValid, // type learnt strobe
  output logic [5:0] fldTypeUnit, // unit whose type is learnt
  output logic [31:0] fldTypeMask // supported blocks
);
  // quiet lines from time zero
  initial
  begin
    {stWrValid, stWrAddr, stWrData} = '0;
    {fldWrValid, fldUnit, fldBlock, fldParam, fldData} = '0;
    {fldTypeValid, fldTypeUnit, fldTypeMask} = '0;
  end

  // one report; called only on a moved value or an update timeout
  task automatic report(input logic [5:0] u, input logic [4:0] b,
                        input logic [2:0] p, input logic [15:0] d);
    begin
      @(negedge clk);
      {fldWrValid, fldUnit, fldBlock, fldParam, fldData} = {1'b1, u, b, p, d};
      @(negedge clk);
      fldWrValid = 1'b0;
      fldData = ~d; // no stale value after release
    end
  endtask : report

  // unit type learnt, mask of blocks it supports
  task automatic set_type(input logic [5:0] u, input logic [31:0] m);
    begin
      @(negedge clk);
      {fldTypeValid, fldTypeUnit, fldTypeMask} = {1'b1, u, m};
      @(negedge clk);
      fldTypeValid = 1'b0;
      fldTypeMask = ~m;
    end
  endtask : set_type

  // station read-only data at locations 0..255
  task automatic station(input logic [7:0] a, input logic [15:0] d);
    begin
      @(negedge clk);
      {stWrValid, stWrAddr, stWrData} = {1'b1, a, d};
      @(negedge clk);
      stWrValid = 1'b0;
      stWrData = ~d;
    end
  endtask : station
endmodule : field_unit_model

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench of the command and database block
// Assumes: 60 units, so block and parameter strides are the real ones
// Notes: inputs change on falling edges, answers sampled on falling edges
`timescale 1ns/1ns
`include "modbus_cmd_db_regs.svh"
module tb_top;
  localparam int UNITS = 60; // full loop size
  logic clk, srst, reqValid, reqReady, rspValid, rspExc, byteValid;
  logic [7:0] reqFunc, rspExcCode, byteData, stWrAddr;
  logic [15:0] reqAddr, reqData, rspData, stWrData, fldData, fwdData;
  logic hotStandbyPair, stWrValid, fldWrValid, fldTypeValid, fwdValid;
  logic [4:0] pulses, fldBlock, fwdBlock; // pulses: reconf..upload
  logic [5:0] fldUnit, fldTypeUnit, fwdUnit;
  logic [2:0] fldParam, fwdParam;
  logic [31:0] fldTypeMask;
  int err_total = 0;
  int n_compared = 0;
  logic gotVld, gotExc, gotFwd, gotRdy; // answer captured in its one cycle
  logic [7:0] gotCode;
  logic [15:0] gotData, gotFwdData;
  logic [13:0] gotFwdTgt;
  logic [4:0] gotPul;
  logic [8:0] gotB0, gotB1; // byte cycles, valid on top

  modbus_cmd_db #(.UNITS(UNITS)) uut (.clk(clk), .srst(srst),
    .reqValid(reqValid), .reqReady(reqReady), .reqFunc(reqFunc),
    .reqAddr(reqAddr), .reqData(reqData), .rspValid(rspValid),
    .rspExc(rspExc), .rspExcCode(rspExcCode), .rspData(rspData),
    .byteValid(byteValid), .byteData(byteData),
    .hotStandbyPair(hotStandbyPair), .loopReconfigure(pulses[4]),
    .roleSwap(pulses[3]), .alarmAccept(pulses[2]),
    .emergencyShutdown(pulses[1]), .uploadStart(pulses[0]),
    .stWrValid(stWrValid), .stWrAddr(stWrAddr), .stWrData(stWrData),
    .fldWrValid(fldWrValid), .fldUnit(fldUnit), .fldBlock(fldBlock),
    .fldParam(fldParam), .fldData(fldData), .fldTypeValid(fldTypeValid),
    .fldTypeUnit(fldTypeUnit), .fldTypeMask(fldTypeMask),
    .fwdValid(fwdValid), .fwdUnit(fwdUnit), .fwdBlock(fwdBlock),
    .fwdParam(fwdParam), .fwdData(fwdData));

  field_unit_model fum (.clk(clk), .stWrValid(stWrValid),
    .stWrAddr(stWrAddr), .stWrData(stWrData), .fldWrValid(fldWrValid),
    .fldUnit(fldUnit), .fldBlock(fldBlock), .fldParam(fldParam),
    .fldData(fldData), .fldTypeValid(fldTypeValid),
    .fldTypeUnit(fldTypeUnit), .fldTypeMask(fldTypeMask));

  // 4 ns clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // verdict and end of run, shared with the watchdog
  task automatic report_and_stop;
    begin
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask : report_and_stop

  // flag vectors
  task automatic chk_flags(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        err_total++;
        $display("ERROR %0t flags %h, want %h", $time, got, exp);
      end
    end
  endtask : chk_flags

  // data values
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        err_total++;
        $display("ERROR %0t value %h, want %h", $time, got, exp);
      end
    end
  endtask : chk_val

  // database location of block, parameter, unit
  function automatic logic [15:0] loc(input int b, input int p, input int u);
    return 16'(256 + (b * 8 + p) * UNITS + u);
  endfunction : loc

  // one request held until taken, then answer and byte cycles captured
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d);
    int n;
    begin
      n = 0;
      @(negedge clk);
      {reqValid, reqFunc, reqAddr, reqData} = {1'b1, f, a, d};
      while (reqReady !== 1'b1 && n < 10)
      begin
        @(negedge clk);
        n++;
      end
      @(negedge clk);
      reqValid = 1'b0;
      reqData = ~d; // released data never shows the old value
      {gotVld, gotExc, gotCode, gotData, gotRdy} =
        {rspValid, rspExc, rspExcCode, rspData, reqReady};
      {gotPul, gotFwd, gotFwdData} = {pulses, fwdValid, fwdData};
      gotFwdTgt = {fwdUnit, fwdBlock, fwdParam};
      @(negedge clk);
      gotB0 = {byteValid, byteData};
      @(negedge clk);
      gotB1 = {byteValid, byteData};
    end
  endtask : xfer

  // write, or refused request: code zero means a normal answer
  task automatic wr(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] d, input logic [7:0] code,
                    input logic [4:0] pul, input logic fw);
    begin
      xfer(f, a, d);
      chk_flags({6'h00, gotRdy, gotVld, gotExc, gotB0[8], gotFwd, gotPul},
                {6'h00, 1'b1, 1'b1, code != 8'h00, 1'b0, fw, pul});
      if (code != 8'h00)
        chk_val({8'h00, gotCode}, {8'h00, code});
      else
        chk_val(gotData, d);
    end
  endtask : wr

  // read with both answer bytes, high byte first
  task automatic rd(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] exp);
    begin
      xfer(f, a, 16'h0000);
      chk_flags({11'h000, gotRdy, gotVld, gotExc, gotB0[8], gotB1[8]},
                16'h000B);
      if (f == `FC_READ_DISCRETE)
        chk_val({15'h0000, gotData[0]}, exp);
      else
      begin
        chk_val(gotData, exp);
        chk_val({gotB0[7:0], gotB1[7:0]}, exp);
      end
    end
  endtask : rd

  // output write passed straight to a unit
  task automatic fw(input logic [7:0] f, input logic [15:0] a,
                    input logic [15:0] d, input logic [13:0] tgt,
                    input logic [15:0] exp);
    begin
      wr(f, a, d, 8'h00, 5'h00, 1'b1);
      chk_val({2'b00, gotFwdTgt}, {2'b00, tgt});
      chk_val(gotFwdData, exp);
    end
  endtask : fw

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #80000;
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial
  begin : main
    logic [7:0] wf [4];
    logic [15:0] wd [4];
    logic [15:0] cl [5];
    logic [4:0] cp [5];
    wf = '{`FC_WRITE_COIL, `FC_WRITE_REG, `FC_WRITE_COILS, `FC_WRITE_REGS};
    wd = '{16'hFF00, 16'h0001, 16'h00FF, 16'h1234};
    cl = '{`LOC_LOOP_RECONFIGURE, `LOC_ROLE_SWAP, `LOC_ALARM_ACCEPT,
           `LOC_SHUTDOWN_BROADCAST, `LOC_UPLOAD_START};
    cp = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    {srst, reqValid, reqFunc, reqAddr, reqData} = {1'b1, 41'h0};
    hotStandbyPair = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    chk_flags({9'h000, reqReady, rspValid, pulses}, 16'h0040);
    // every command by every write function
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 5; j++)
        wr(wf[i], cl[j], wd[i], 8'h00, cp[j],
           1'b0);
    for (int j = 0; j < 5; j++)
      wr(`FC_WRITE_REG, cl[j], 16'h0000, 8'h00, 5'h00, 1'b0);
    hotStandbyPair = 1'b0;
    wr(`FC_WRITE_REG, `LOC_ROLE_SWAP, 16'h0001, 8'h00, 5'h00, 1'b0);
    hotStandbyPair = 1'b1;
    // refused writes and functions
    wr(`FC_WRITE_REG, 16'h0007, 16'h0001, `EXC_ILLEGAL_ADDRESS,
       5'h00, 1'b0);
    wr(`FC_WRITE_COIL, 16'h00FE, 16'hFF00, `EXC_ILLEGAL_ADDRESS,
       5'h00, 1'b0);
    wr(`FC_WRITE_REGS, loc(2, 0, 0), 16'h0001, `EXC_ILLEGAL_ADDRESS,
       5'h00, 1'b0);
    wr(8'h01, 16'h0003, 16'h0001, `EXC_ILLEGAL_FUNCTION, 5'h00, 1'b0);
    // command location reads station data
    fum.station(8'h03, 16'hA5C3);
    wr(`FC_WRITE_REG, `LOC_LOOP_RECONFIGURE, 16'h1111, 8'h00, 5'h10, 1'b0);
    rd(`FC_READ_HOLDING, `LOC_LOOP_RECONFIGURE, 16'hA5C3);
    // database reads
    fum.set_type(6'h00, 32'hFFFF_FFFF);
    fum.set_type(6'h01, 32'hFFFF_FFFF);
    fum.set_type(6'h3B, 32'hFFFF_FFFF);
    fum.set_type(6'h02, 32'hFFFF_FF7F);
    fum.report(6'h00, 5'h07, 3'h2, 16'hBEEF);
    rd(`FC_READ_INPUT, loc(7, 2, 0), 16'hBEEF);
    fum.report(6'h00, 5'h07, 3'h2, 16'h1357);
    rd(`FC_READ_INPUT, loc(7, 2, 0), 16'h1357);
    fum.report(6'h3B, 5'h1F, 3'h7, 16'h8001);
    rd(`FC_READ_INPUT, loc(31, 7, 59), 16'h8001);
    wr(`FC_READ_INPUT, loc(31, 7, 59) + 16'h0001, 16'h0000,
       `EXC_ILLEGAL_ADDRESS, 5'h00, 1'b0);
    fum.report(6'h02, 5'h07, 3'h0, 16'hFFFF);
    rd(`FC_READ_INPUT, loc(7, 0, 2), 16'h0000);
    fum.report(6'h01, `BLK_DIGITAL, 3'h0, 16'h0005);
    rd(`FC_READ_DISCRETE, `DI_DISC_BASE + 16'h0010, 16'h0001);
    rd(`FC_READ_DISCRETE, `DI_DISC_BASE + 16'h0011, 16'h0000);
    rd(`FC_READ_INPUT, loc(2, 0, 1), 16'h0005);
    // outputs forwarded, relay value 0 or 1, nothing kept locally
    fum.report(6'h00, `BLK_RELAY, 3'h0, 16'h0000);
    fw(`FC_WRITE_COIL, loc(4, 0, 0), 16'hFF00, 14'h0020,
       16'h0001);
    fw(`FC_WRITE_REGS, loc(4, 0, 0), 16'h0000, 14'h0020,
       16'h0000);
    fw(`FC_WRITE_REG, loc(4, 0, 0), 16'h00FF, 14'h0020,
       16'h0001);
    fw(`FC_WRITE_COILS, loc(5, 1, 3), 16'h0123, 14'h0329,
       16'h0123);
    rd(`FC_READ_INPUT, loc(4, 0, 0), 16'h0000);
    // alarm latch: accept before read keeps it, live bit survives
    fum.report(6'h00, `BLK_DIGITAL, 3'h0, 16'h0005);
    fum.report(6'h00, `BLK_ALARM, 3'h0, 16'h000C);
    rd(`FC_READ_INPUT, loc(2, 0, 0), 16'h1805);
    fum.report(6'h00, `BLK_ALARM, 3'h0, 16'h0008);
    wr(`FC_WRITE_REG, `LOC_ALARM_ACCEPT, 16'h0001, 8'h00, 5'h04, 1'b0);
    rd(`FC_READ_INPUT, loc(3, 0, 0), 16'h000C);
    rd(`FC_READ_INPUT, loc(2, 0, 0), 16'h1005);
    wr(`FC_WRITE_REG, `LOC_ALARM_ACCEPT, 16'h0001, 8'h00, 5'h04, 1'b0);
    rd(`FC_READ_INPUT, loc(3, 0, 0), 16'h0008);
    report_and_stop();
  end
endmodule : tb_top
